// ===== common/sensor_cfg_pkg.sv
// shared register map, field positions and types for the sensor config link
package sensor_cfg_pkg;
  localparam int          ADDR_W          = 9;
  localparam int          DATA_W          = 16;
  localparam int          WIN_NUM         = 32;
  localparam logic [8:0]  reg_clk_gen     = 9'h020;
  localparam logic [8:0]  reg_logic_en    = 9'h022;
  localparam logic [8:0]  reg_image_core  = 9'h028;
  localparam logic [8:0]  reg_front_end   = 9'h030;
  localparam logic [8:0]  reg_bias_lo     = 9'h040;
  localparam logic [8:0]  reg_bias_hi     = 9'h047;
  localparam logic [8:0]  reg_lvds        = 9'h070;
  localparam logic [8:0]  reg_black_lo    = 9'h080;
  localparam logic [8:0]  reg_black_hi    = 9'h081;
  localparam logic [8:0]  reg_sync_lo     = 9'h082;
  localparam logic [8:0]  reg_sync_hi     = 9'h087;
  localparam logic [8:0]  reg_test_lo     = 9'h090;
  localparam logic [8:0]  reg_test_hi     = 9'h096;
  localparam logic [8:0]  shutter_operation_mode_control = 9'h0c0;
  localparam logic [8:0]  reg_win_act_lo  = 9'h0c3;
  localparam logic [8:0]  reg_win_act_hi  = 9'h0c4;
  localparam logic [8:0]  reg_black_lines = 9'h0c5;
  localparam logic [8:0]  reg_dummy_lines = 9'h0c6;
  localparam logic [8:0]  reg_expo_lo     = 9'h0c7;
  localparam logic [8:0]  reg_expo_hi     = 9'h0c9;
  localparam logic [8:0]  reg_gain        = 9'h0cc;
  localparam logic [8:0]  reg_sync_cfg    = 9'h0ce;
  localparam logic [8:0]  reg_roi_lo      = 9'h100;
  localparam logic [8:0]  reg_roi_hi      = 9'h15f;
  localparam int          b_seq_en        = 0;
  localparam int          b_rolling       = 1;
  localparam int          b_triggered     = 4;
  localparam int          b_slave         = 5;
  localparam int          b_subsample     = 7;
  localparam int          b_binning       = 8;
  localparam int          b_expo_sync     = 11;
  localparam int          b_gain_lat      = 13;
  localparam int          b_blank_roi     = 8;
  localparam int          b_sync_bit      = 13;
  localparam logic [15:0] mode_mask       = 16'h01b2;
  localparam logic [15:0] logic_off       = 16'h0000;
  localparam logic [15:0] mode_reset      = 16'h0000;
  localparam logic [15:0] win_lo_reset    = 16'h0001;
  localparam logic [15:0] word_zero       = 16'h0000;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_run   = 2'b01,
    st_blank = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    hs_idle  = 2'b00,
    hs_read  = 2'b01,
    hs_write = 2'b11
  } host_state_t;
endpackage

// ===== common/sensor_cfg_if.sv
// register write/read link between host controller and sensor config block
`timescale 1ns/1ps
interface sensor_cfg_if;
  logic        wr_en;
  logic        rd_en;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;

  modport sensor (
    input  wr_en,
    input  rd_en,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid
  );
  modport host (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface

// ===== design/sensor_mode_reconfig_control.sv
// sensor end: register bank with frame-synchronised active copies
// Function
// - host writes zero to 34 stopping logic
// - shutter fields (bits 1, 4, 5) change only standby/idle
// - bit1 picks global or rolling shutter
// - bit4 picks triggered mode, global only
// - bit5 picks slave mode, global only
// - bit7 subsampling, bit8 binning enables
// - window registers writable in every state
// - after reset window zero only, full
// - exposure and gain writable in every state
// - static group changed with sequencer off
// - host keeps reserved registers at default
// - black-level rewrites flag calibration disturbance
// - sync-code writes flag current frame codes
// - test-pattern writes flag one transient frame
// - frame parameters apply at next boundary
// - settling change blanks frame with training
// - subsample/binning change only at frame start
// - black-line change blanks rolling frame only
// - dummy-line change blanks rolling frame only
// - window switch blanks when enabled, rolling
// - exposure one frame late, except triggered master
// - gain at frame start, optional extra frame
// - sequencer enable starts, clear returns idle
`timescale 1ns/1ps
module sensor_mode_reconfig_control #(
  parameter int WIN_N = sensor_cfg_pkg::WIN_NUM
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  sensor_cfg_if.sensor                cfg,
  input  wire logic                   frame_start,
  output logic                        seq_running,
  output logic                        logic_enabled,
  output logic                        rolling_shutter,
  output logic                        triggered_mode,
  output logic                        slave_mode,
  output logic                        subsample_en,
  output logic                        binning_en,
  output logic                        training_out,
  output logic [WIN_N-1:0]            active_windows,
  output logic [15:0]                 active_exposure,
  output logic [15:0]                 active_gain,
  output logic                        black_cal_disturb,
  output logic                        sync_code_suspect,
  output logic                        test_pattern_suspect
);
  import sensor_cfg_pkg::*;

  // window field is fixed at two 16-bit words
  if (WIN_N != 32) begin : g_win_check
    $error("only 32 windows supported");
  end

  typedef struct packed {
    seq_state_t  st;
    logic [15:0] mode;
    logic [15:0] logic_en;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic [15:0] black_lines;
    logic [15:0] dummy_lines;
    logic [15:0] expo;
    logic [15:0] gain;
    logic [15:0] sync_cfg;
    logic        blank_pend;
    logic        expo_pend;
    logic        gain_pend;
    logic        gain_pend2;
    logic [15:0] gain_stage;
    logic [1:0]  act_sub_bin;
    logic [31:0] act_win;
    logic [15:0] act_expo;
    logic [15:0] act_gain;
    logic        black_dist;
    logic        sync_susp;
    logic        test_susp;
    logic        test_pend;
    logic [15:0] rdata;
    logic        rvalid;
    logic        o_run;
    logic        o_logic;
    logic        o_trig;
    logic        o_slave;
    logic        o_train;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;
  logic   rolling;

  always_comb begin
    nxt_ff = cur_ff;
    rolling = cur_ff.mode[b_rolling];
    nxt_ff.rvalid = cfg.rd_en;
    nxt_ff.rdata = word_zero;
    if (cfg.rd_en) begin
      unique case (cfg.addr)
        shutter_operation_mode_control: nxt_ff.rdata = cur_ff.mode;
        reg_logic_en:                   nxt_ff.rdata = cur_ff.logic_en;
        reg_win_act_lo:                 nxt_ff.rdata = cur_ff.win_lo;
        reg_win_act_hi:                 nxt_ff.rdata = cur_ff.win_hi;
        reg_black_lines:                nxt_ff.rdata = cur_ff.black_lines;
        reg_dummy_lines:                nxt_ff.rdata = cur_ff.dummy_lines;
        reg_expo_lo:                    nxt_ff.rdata = cur_ff.expo;
        reg_gain:                       nxt_ff.rdata = cur_ff.gain;
        reg_sync_cfg:                   nxt_ff.rdata = cur_ff.sync_cfg;
        default:                        nxt_ff.rdata = word_zero;
      endcase
    end
    // frame boundary: load active copies
    if (frame_start) begin
      nxt_ff.sync_susp = 1'b0;
      nxt_ff.test_susp = cur_ff.test_pend;
      nxt_ff.test_pend = 1'b0;
      nxt_ff.act_sub_bin = {cur_ff.mode[b_binning], cur_ff.mode[b_subsample]};
      nxt_ff.act_win = {cur_ff.win_hi, cur_ff.win_lo};
      if (cur_ff.expo_pend) begin
        nxt_ff.act_expo = cur_ff.expo;
        nxt_ff.expo_pend = 1'b0;
      end
      if (cur_ff.gain_pend2) begin
        nxt_ff.act_gain = cur_ff.gain_stage;
        nxt_ff.gain_pend2 = 1'b0;
      end
      if (cur_ff.gain_pend) begin
        nxt_ff.gain_pend = 1'b0;
        if (cur_ff.gain[b_gain_lat]) begin
          nxt_ff.gain_stage = cur_ff.gain;
          nxt_ff.gain_pend2 = 1'b1;
        end else begin
          nxt_ff.act_gain = cur_ff.gain;
        end
      end
      unique case (cur_ff.st)
        st_idle: nxt_ff.st = st_idle;
        st_run: begin
          if (cur_ff.blank_pend) nxt_ff.st = st_blank;
          nxt_ff.blank_pend = 1'b0;
        end
        st_blank: nxt_ff.st = st_run;
        default: nxt_ff.st = st_idle;
      endcase
    end
    if (cfg.wr_en) begin
      if (cur_ff.st != st_idle && ((cfg.addr >= reg_black_lo && cfg.addr <= reg_black_hi) ||
          (cfg.addr == reg_black_lines && cfg.wdata[8] != cur_ff.black_lines[8])))
        nxt_ff.black_dist = 1'b1;
      if ((cfg.addr == reg_black_hi && cfg.wdata[b_sync_bit]) ||
          (cfg.addr >= reg_sync_lo && cfg.addr <= reg_sync_hi))
        nxt_ff.sync_susp = 1'b1;
      if (cur_ff.st != st_idle && cfg.addr >= reg_test_lo && cfg.addr <= reg_test_hi)
        nxt_ff.test_pend = 1'b1;
      unique case (cfg.addr)
        reg_logic_en: nxt_ff.logic_en = cfg.wdata;
        shutter_operation_mode_control: begin
          nxt_ff.mode[b_seq_en] = cfg.wdata[b_seq_en];
          if (!cfg.wdata[b_seq_en]) nxt_ff.st = st_idle;
          else if (cur_ff.st == st_idle) nxt_ff.st = st_run;
          // shutter bits latched while idle only; sub, bin and expo-sync bits follow every write
          if (cur_ff.st == st_idle)
            nxt_ff.mode = (cur_ff.mode & ~mode_mask) | (cfg.wdata & mode_mask)
                          | {15'h0000, cfg.wdata[b_seq_en]};
          nxt_ff.mode[b_subsample] = cfg.wdata[b_subsample];
          nxt_ff.mode[b_binning] = cfg.wdata[b_binning];
          nxt_ff.mode[b_expo_sync] = cfg.wdata[b_expo_sync];
        end
        reg_win_act_lo, reg_win_act_hi: begin
          if (cfg.addr == reg_win_act_lo) nxt_ff.win_lo = cfg.wdata;
          else nxt_ff.win_hi = cfg.wdata;
          if (rolling && cur_ff.sync_cfg[b_blank_roi] &&
              cfg.wdata != (cfg.addr == reg_win_act_lo ? cur_ff.win_lo : cur_ff.win_hi))
            nxt_ff.blank_pend = 1'b1;
        end
        reg_black_lines: begin
          nxt_ff.black_lines = cfg.wdata;
          if (rolling && cfg.wdata[7:0] != cur_ff.black_lines[7:0]) nxt_ff.blank_pend = 1'b1;
        end
        reg_dummy_lines: begin
          nxt_ff.dummy_lines = cfg.wdata;
          if (rolling && cfg.wdata != cur_ff.dummy_lines) nxt_ff.blank_pend = 1'b1;
        end
        reg_expo_lo: begin
          nxt_ff.expo = cfg.wdata;
          if (!rolling && cur_ff.mode[b_triggered] && !cur_ff.mode[b_slave] &&
              cur_ff.mode[b_expo_sync])
            nxt_ff.act_expo = cfg.wdata;
          else
            nxt_ff.expo_pend = 1'b1;
        end
        reg_gain: begin
          nxt_ff.gain = cfg.wdata;
          nxt_ff.gain_pend = 1'b1;
        end
        reg_sync_cfg: nxt_ff.sync_cfg = cfg.wdata;
        // roi geometry taken, not stored here
        default: ;
      endcase
    end
    // outputs registered from the next state
    // run flag
    nxt_ff.o_run = nxt_ff.st != st_idle;
    nxt_ff.o_logic = nxt_ff.logic_en != logic_off;
    nxt_ff.o_trig = nxt_ff.mode[b_triggered] & ~nxt_ff.mode[b_rolling];
    nxt_ff.o_slave = nxt_ff.mode[b_slave] & ~nxt_ff.mode[b_rolling];
    nxt_ff.o_train = nxt_ff.st == st_blank;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.win_lo <= win_lo_reset;
      cur_ff.act_win <= {16'h0000, win_lo_reset};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign cfg.rdata = cur_ff.rdata;
  assign cfg.rvalid = cur_ff.rvalid;
  assign seq_running = cur_ff.o_run;
  assign logic_enabled = cur_ff.o_logic;
  assign rolling_shutter = cur_ff.mode[b_rolling];
  assign triggered_mode = cur_ff.o_trig;
  assign slave_mode = cur_ff.o_slave;
  assign subsample_en = cur_ff.act_sub_bin[0];
  assign binning_en = cur_ff.act_sub_bin[1];
  assign training_out = cur_ff.o_train;
  assign active_windows = cur_ff.act_win;
  assign active_exposure = cur_ff.act_expo;
  assign active_gain = cur_ff.act_gain;
  assign black_cal_disturb = cur_ff.black_dist;
  assign sync_code_suspect = cur_ff.sync_susp;
  assign test_pattern_suspect = cur_ff.test_susp;
endmodule

// ===== design/sensor_cfg_host.sv
// host end: issues single writes and read-modify-writes of the mode register
`timescale 1ns/1ps
module sensor_cfg_host (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  sensor_cfg_if.host       cfg,
  input  wire logic        req_valid,
  input  wire logic        req_mode,
  input  wire logic [8:0]  req_addr,
  input  wire logic [15:0] req_data,
  input  wire logic        seq_running,
  output logic             req_ready,
  output logic             req_refused,
  output logic             req_done
);
  import sensor_cfg_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic        wr_en;
    logic        rd_en;
    logic [8:0]  addr;
    logic [15:0] wdata;
    logic [15:0] hold;
    logic        refused;
    logic        done;
    logic        ready;
  } hstate_t;

  hstate_t cur_ff;
  hstate_t nxt_ff;
  logic    static_hit;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wr_en = 1'b0;
    nxt_ff.rd_en = 1'b0;
    nxt_ff.refused = 1'b0;
    nxt_ff.done = 1'b0;
    static_hit = req_addr == reg_clk_gen || req_addr == reg_image_core || req_addr == reg_front_end ||
                 (req_addr >= reg_bias_lo && req_addr <= reg_bias_hi) || req_addr == reg_lvds;
    unique case (cur_ff.st)
      hs_idle: begin
        if (req_valid) begin
          if (static_hit && seq_running) begin
            nxt_ff.refused = 1'b1;
          end else if (req_mode) begin
            nxt_ff.rd_en = 1'b1;
            nxt_ff.addr = shutter_operation_mode_control;
            nxt_ff.hold = req_data;
            nxt_ff.st = hs_read;
          end else begin
            nxt_ff.wr_en = 1'b1;
            nxt_ff.addr = req_addr;
            nxt_ff.wdata = req_data;
            nxt_ff.st = hs_write;
          end
        end
      end
      hs_read: begin
        if (cfg.rvalid) begin
          nxt_ff.wr_en = 1'b1;
          // other bits unchanged
          // whole register frozen while running, only enable follows
          if (seq_running)
            nxt_ff.wdata = cfg.rdata;
          else
            nxt_ff.wdata = (cfg.rdata & ~mode_mask) | (cur_ff.hold & mode_mask)
                           | (cfg.rdata & cur_ff.hold & 16'h0001);
          nxt_ff.wdata[b_seq_en] = cur_ff.hold[b_seq_en];
          nxt_ff.st = hs_write;
        end
      end
      hs_write: begin
        nxt_ff.done = 1'b1;
        nxt_ff.st = hs_idle;
      end
      default: nxt_ff.st = hs_idle;
    endcase
    nxt_ff.ready = nxt_ff.st == hs_idle;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur_ff <= '0;
      cur_ff.ready <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign cfg.wr_en = cur_ff.wr_en;
  assign cfg.rd_en = cur_ff.rd_en;
  assign cfg.addr = cur_ff.addr;
  assign cfg.wdata = cur_ff.wdata;
  assign req_ready = cur_ff.ready;
  assign req_refused = cur_ff.refused;
  assign req_done = cur_ff.done;
endmodule

// ===== testbench/sensor_cfg_monitor.sv
// concurrent checks on the config link and the sensor frame outputs
`timescale 1ns/1ps
module sensor_cfg_monitor
  import sensor_cfg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [8:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        frame_start,
  input wire logic        rolling_shutter,
  input wire logic        triggered_mode,
  input wire logic        slave_mode,
  input wire logic        training_out,
  input wire logic [15:0] active_exposure
);
  // bits outside every field the host may touch in a mode update
  localparam logic [15:0] keep = 16'hf64c;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_rmw_rd;
    rd_en && addr == shutter_operation_mode_control;
  endsequence
  sequence s_rmw_wr;
    wr_en && addr == shutter_operation_mode_control;
  endsequence
  property p_rd_answer;
    rd_en |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered next cycle");
  property p_rvalid_cause;
    rvalid |-> $past(rd_en);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("read data valid without a read strobe");
  property p_rmw_write;
    s_rmw_rd |-> ##2 s_rmw_wr;
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("mode read not followed by its write");
  property p_rmw_keep;
    s_rmw_rd ##1 rvalid |=> wr_en && ((wdata & keep) == ($past(rdata) & keep));
  endproperty
  a_rmw_keep: assert property (p_rmw_keep) else $error("mode update altered foreign bits");
  property p_global_only;
    rolling_shutter |-> !triggered_mode && !slave_mode;
  endproperty
  a_global_only: assert property (p_global_only) else $error("trigger or slave mode in rolling shutter");
  property p_training_start;
    $rose(training_out) |-> $past(frame_start);
  endproperty
  a_training_start: assert property (p_training_start) else $error("blanking began off a frame edge");
  property p_training_hold;
    training_out && !frame_start |=> training_out;
  endproperty
  a_training_hold: assert property (p_training_hold) else $error("blanking ended mid frame");
  property p_expo_sync;
    $changed(active_exposure) |-> $past(frame_start) || (triggered_mode && !slave_mode && !rolling_shutter);
  endproperty
  a_expo_sync: assert property (p_expo_sync) else $error("exposure changed inside a frame");
endmodule

// ===== testbench/sensor_mode_reconfig_control_test.sv
// self-checking bench: host end and sensor end joined over the config link
`timescale 1ns/1ps
module sensor_mode_reconfig_control_test;
  import sensor_cfg_pkg::*;
  logic sys_clk = 0, reset = 1, frame_start = 0, req_valid = 0, req_mode = 0;
  logic [8:0]  req_addr = '0;
  logic [15:0] req_data = '0, v;
  logic [31:0] seed = 32'd16717;
  logic seq_running, logic_enabled, rolling_shutter, triggered_mode, slave_mode, subsample_en, binning_en;
  logic training_out, black_cal_disturb, sync_code_suspect, test_pattern_suspect, req_ready, req_refused, req_done;
  logic        rf, tp_seen;
  logic [15:0] pv, bl;
  logic [31:0] active_windows;
  logic [15:0] active_exposure, active_gain;
  int          error_cnt = 0, tests_run = 0;
  logic [15:0] corner [5] = '{16'h0000, 16'h0002, 16'h0030, 16'h0180, 16'h01b2};
  sensor_cfg_if cfg_if();
  sensor_mode_reconfig_control sensor_mode_reconfig_control_i (.sys_clk(sys_clk), .reset(reset), .cfg(cfg_if),
    .frame_start(frame_start), .seq_running(seq_running), .logic_enabled(logic_enabled),
    .rolling_shutter(rolling_shutter), .triggered_mode(triggered_mode), .slave_mode(slave_mode),
    .subsample_en(subsample_en), .binning_en(binning_en), .training_out(training_out),
    .active_windows(active_windows), .active_exposure(active_exposure), .active_gain(active_gain),
    .black_cal_disturb(black_cal_disturb), .sync_code_suspect(sync_code_suspect),
    .test_pattern_suspect(test_pattern_suspect));
  sensor_cfg_host sensor_cfg_host_i (.sys_clk(sys_clk), .reset(reset), .cfg(cfg_if), .req_valid(req_valid),
    .req_mode(req_mode), .req_addr(req_addr), .req_data(req_data), .seq_running(seq_running),
    .req_ready(req_ready), .req_refused(req_refused), .req_done(req_done));
  sensor_cfg_monitor sensor_cfg_monitor_i (.sys_clk(sys_clk), .reset(reset), .wr_en(cfg_if.wr_en),
    .rd_en(cfg_if.rd_en), .addr(cfg_if.addr), .wdata(cfg_if.wdata), .rdata(cfg_if.rdata),
    .rvalid(cfg_if.rvalid), .frame_start(frame_start), .rolling_shutter(rolling_shutter),
    .triggered_mode(triggered_mode), .slave_mode(slave_mode), .training_out(training_out),
    .active_exposure(active_exposure));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // expected {rolling, triggered, slave}: the last two exist in global shutter only
  function automatic logic [2:0] mode_exp(input logic [15:0] d);
    return {d[b_rolling], d[b_triggered] & ~d[b_rolling], d[b_slave] & ~d[b_rolling]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // one request, presented for one cycle once ready, then a bounded wait for done or refusal
  task automatic req(input logic m, input logic [8:0] a, input logic [15:0] d, output logic refused);
    int n;
    n = 0;
    refused = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    req_mode = m;
    req_addr = a;
    req_data = d;
    req_valid = 1;
    tick();
    req_valid = 0;
    n = 0;
    while (req_done !== 1'b1 && req_refused !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    refused = (req_refused === 1'b1);
    if (n == 20) chk("request completion", 1, 0);
    if (test_pattern_suspect === 1'b1) tp_seen = 1;
    tick();
  endtask
  task automatic fs();
    frame_start = 1;
    tick();
    frame_start = 0;
    if (test_pattern_suspect === 1'b1) tp_seen = 1;
    tick();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    tp_seen = 0;
    repeat (3) @(posedge sys_clk);
    #1 reset = 0;
    tick();
    chk("mode after reset", 0, {rolling_shutter, triggered_mode, slave_mode, subsample_en, binning_en});
    chk("windows after reset", 1, active_windows);
    chk("seq after reset", 0, seq_running);
    $display("test reset done");
    pv = 16'h0000;
    for (int i = 0; i < 10; i++) begin
      v = (i < 5) ? corner[i] : (rnd() & mode_mask);
      req(1, shutter_operation_mode_control, v, rf);
      chk("sub and bin before frame", {pv[b_subsample], pv[b_binning]}, {subsample_en, binning_en});
      fs();
      chk("shutter modes", mode_exp(v), {rolling_shutter, triggered_mode, slave_mode});
      chk("sub and bin", {v[b_subsample], v[b_binning]}, {subsample_en, binning_en});
      pv = v;
    end
    $display("test mode sweep done");
    req(0, reg_logic_en, 16'h0001, rf);
    chk("logic on", 1, logic_enabled);
    req(0, reg_logic_en, logic_off, rf);
    chk("logic off", 0, logic_enabled);
    $display("test logic enable done");
    req(0, shutter_operation_mode_control, 16'h0001, rf);
    chk("seq start", 1, seq_running);
    v = rnd();
    req(0, reg_expo_lo, v, rf);
    chk("expo held", 0, active_exposure);
    fs();
    chk("expo applied", v, active_exposure);
    v = rnd() & 16'hdfff;
    req(0, reg_gain, v, rf);
    fs();
    chk("gain next frame", v, active_gain);
    pv = v;
    v = rnd() | 16'h2000;
    req(0, reg_gain, v, rf);
    fs();
    chk("gain extra frame", pv, active_gain);
    fs();
    chk("gain late", v, active_gain);
    req(0, reg_clk_gen, 16'h2003, rf);
    chk("static refused", 1, rf);
    bl = rnd();
    req(0, reg_black_lines, bl, rf);
    fs();
    chk("global no blank", 0, training_out);
    req(0, reg_black_lo, rnd(), rf);
    chk("black disturb", 1, black_cal_disturb);
    req(0, reg_sync_lo, rnd(), rf);
    chk("sync suspect", 1, sync_code_suspect);
    fs();
    chk("sync clears", 0, sync_code_suspect);
    req(0, reg_test_lo, rnd(), rf);
    fs();
    chk("test suspect", 1, tp_seen);
    $display("test global running done");
    req(0, shutter_operation_mode_control, 16'h0000, rf);
    fs();
    req(0, shutter_operation_mode_control, 16'h0002, rf);
    req(0, reg_sync_cfg, 16'h0100, rf);
    req(0, shutter_operation_mode_control, 16'h0003, rf);
    req(1, shutter_operation_mode_control, 16'h0001, rf);
    chk("mode locked running", 1, rolling_shutter);
    req(0, reg_win_act_lo, 16'h0004, rf);
    fs();
    chk("window switch blank", 1, training_out);
    chk("window active", 32'h4, active_windows);
    fs();
    chk("blank one frame", 0, training_out);
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      // an unchanged count would rightly not blank
      if ((i == 0) ? (v[7:0] == bl[7:0]) : (v == word_zero)) v[0] = ~v[0];
      req(0, (i == 0) ? reg_black_lines : reg_dummy_lines, v, rf);
      fs();
      chk("line count blank", 1, training_out);
      fs();
      chk("line blank ends", 0, training_out);
    end
    req(0, reg_roi_lo, rnd(), rf);
    fs();
    chk("resize no blank", 0, training_out);
    $display("test rolling done");
    req(0, shutter_operation_mode_control, 16'h0002, rf);
    fs();
    chk("seq stop", 0, seq_running);
    req(0, shutter_operation_mode_control, 16'h0810, rf);
    req(0, shutter_operation_mode_control, 16'h0811, rf);
    v = rnd();
    req(0, reg_expo_lo, v, rf);
    chk("expo bypass", v, active_exposure);
    $display("test exposure bypass done");
    conclude();
  end
endmodule
